// [drv_ctl_pkg.sv]
// Purpose: Shared constants and types for the output driver control registers.
// Assumes: Seven-bit register addresses within a page, eight-bit data.
// Notes:   Bit positions are given from bit 0 of each register.
`default_nettype none
package drv_ctl_pkg;
   // ==========================================================================
   // Register addresses
   localparam logic [6:0] PAGE_REG_ADDR  = 7'h00;
   localparam logic [6:0] ERR_REG_ADDR   = 7'h1E;
   localparam logic [6:0] HP_REG_ADDR    = 7'h1F;
   localparam logic [6:0] SPK_REG_ADDR   = 7'h20;
   localparam logic [6:0] GAIN_REG_ADDR  = 7'h75;
   localparam logic [6:0] RSV0_LO_ADDR   = 7'h76;
   localparam logic [6:0] RSV0_HI_ADDR   = 7'h7F;
   localparam logic [6:0] RSV1_LO_ADDR   = 7'h01;
   localparam logic [6:0] RSV1_HI_ADDR   = 7'h1D;
   localparam logic [7:0] PAGE_ZERO      = 8'h00;
   localparam logic [7:0] PAGE_ONE       = 8'h01;
   // ==========================================================================
   // Reset values
   localparam logic [7:0] PAGE_RESET     = 8'h00;
   localparam logic [7:0] ERR_RESET      = 8'h00;
   localparam logic [7:0] HP_RESET       = 8'h04;
   localparam logic [7:0] SPK_RESET      = 8'h06;
   localparam logic       GAIN_RSV_RESET = 1'b0;
   // ==========================================================================
   // Field positions
   localparam int HP_LEFT_BIT     = 7;
   localparam int HP_RIGHT_BIT    = 6;
   localparam int HP_CM_LSB       = 3;
   localparam int HP_ACTION_BIT   = 1;
   localparam int HP_STATUS_BIT   = 0;
   localparam int ERR_SPK_KEEP_BIT = 1;
   localparam int ERR_HP_KEEP_BIT = 0;
   localparam int SPK_LEFT_BIT    = 7;
   localparam int SPK_RIGHT_BIT   = 6;
   localparam int SPK_STATUS_BIT  = 0;
   localparam int GAIN_RSV_BIT    = 7;
   // ==========================================================================
   // Gain readout codes, in half-decibel steps
   localparam logic [6:0] GAIN_CODE_UNITY    = 7'h24;
   localparam logic [6:0] GAIN_CODE_KNEE     = 7'h5A;
   localparam logic [6:0] GAIN_CODE_RESERVED = 7'h7F;
   localparam int         GAIN_TOP_HALF_DB   = 36;
   localparam int         GAIN_KNEE_HALF_DB  = -54;
   // ==========================================================================
   // Types
   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_ADDR      = 9'h002,
      ST_ADDR_ACK  = 9'h004,
      ST_PTR       = 9'h008,
      ST_PTR_ACK   = 9'h010,
      ST_WDATA     = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA     = 9'h080,
      ST_RDATA_ACK = 9'h100
   } port_state_type;
   typedef struct packed {
      logic       left_up;
      logic       right_up;
      logic [1:0] common_mode;
      logic       current_limit;
   } hp_drive_type;
   typedef struct packed {
      logic left_up;
      logic right_up;
   } spk_drive_type;
   typedef struct packed {
      logic spk_keep;
      logic hp_keep;
      logic hp_action;
   } err_cfg_type;
endpackage
`default_nettype wire

// [gain_readout.sv]
// Purpose: Holds the gain code reported by the pin volume converter.
// Assumes: The converter offers a code with a one-cycle valid strobe.
// Notes:   The reserved all-ones code is never latched.
`timescale 1ns/1ns
`default_nettype none
module gain_readout #(
   parameter int GAIN_W = 7
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   // Converter side
   input  wire logic [GAIN_W-1:0]        code_in,
   input  wire logic                     code_valid,
   // Readout
   output logic      [GAIN_W-1:0]        code_q,
   output logic signed [7:0]             half_db_q
);
   import drv_ctl_pkg::*;
   if (GAIN_W != 7) begin : gen_bad_width
      $error("gain_readout serves only a seven-bit code");
   end
   // ==========================================================================
   // Code to gain
   function automatic logic signed [7:0] to_half_db(input logic [6:0] code);
      int g;
      if (code < GAIN_CODE_KNEE) begin
         g = GAIN_TOP_HALF_DB - int'(code);
      end else begin
         g = GAIN_KNEE_HALF_DB - 2 * (int'(code) - int'(GAIN_CODE_KNEE));
      end
      return 8'(g);
   endfunction
   logic [GAIN_W-1:0] code_d;
   logic signed [7:0] half_db_d;
   always_comb begin
      code_d    = code_q;
      half_db_d = half_db_q;
      // A reserved code would read back as a gain, so the last good code stays.
      if (code_valid && code_in != GAIN_CODE_RESERVED) begin
         code_d    = code_in;
         half_db_d = to_half_db(code_in);
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         code_q    <= GAIN_CODE_UNITY;
         half_db_q <= 8'sh00;
      end else begin
         code_q    <= code_d;
         half_db_q <= half_db_d;
      end
   end
endmodule
`default_nettype wire

// [short_guard.sv]
// Purpose: Decides the response of the drivers to a detected short circuit.
// Assumes: Short inputs are levels, high while the short is present.
// Notes:   Purely combinational; the caller registers every result.
`timescale 1ns/1ns
`default_nettype none
module short_guard (
   // Detect inputs
   input  wire logic                     hp_short,
   input  wire logic                     spk_short,
   // Configuration
   input  wire drv_ctl_pkg::err_cfg_type cfg,
   // Actions
   output logic                          hp_clear,
   output logic                          spk_clear,
   output logic                          hp_cut,
   output logic                          hp_limit
);
   import drv_ctl_pkg::*;
   always_comb begin
      spk_clear = spk_short && !cfg.spk_keep;
      hp_clear  = hp_short && !cfg.hp_keep && cfg.hp_action;
      hp_cut    = hp_short && cfg.hp_action;
      hp_limit  = hp_short && !cfg.hp_action;
   end
endmodule
`default_nettype wire

// [output_driver_ctl_regs.sv]
// Purpose: Control and status registers for the headphone and speaker drivers.
// Assumes: Serial control port pins are synchronous to clock and sampled here.
// Notes:   Register pointer auto-increments on every data byte.
//
// How it works
// - seven-bit read-only gain readout, all-ones reserved
// - code 0100100 reports unity gain
// - low end codes step one decibel
// - page register eight bits, resets zero
// - speaker short clears speaker power bits
// - speaker keep bit holds power bits
// - headphone short clears power bits when enabled
// - headphone keep bit holds power bits
// - bit seven powers left headphone driver
// - bit six powers right headphone driver
// - two bits select output common mode
// - action bit clear limits load current
// - action bit set powers driver down
// - bit zero shows headphone short status
// - speaker register bits seven, six power drivers
`timescale 1ns/1ns
`default_nettype none
module output_driver_ctl_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h2A
) (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       arst_n,
   // Serial control port
   input  wire logic                       scl_in,
   input  wire logic                       sda_in,
   output logic                            sda_out,
   output logic                            sda_oe,
   // Analogue driver status
   input  wire logic                       hp_short_detect,
   input  wire logic                       spk_short_detect,
   // Pin volume converter
   input  wire logic [6:0]                 vol_code,
   input  wire logic                       vol_code_valid,
   output logic signed [7:0]               vol_gain_half_db,
   // Driver controls
   output drv_ctl_pkg::hp_drive_type       hp_drive,
   output drv_ctl_pkg::spk_drive_type      spk_drive
);
   import drv_ctl_pkg::*;
   if (DEV_ADDR > 7'h77) begin : gen_bad_addr
      $error("DEV_ADDR lies in the reserved address space");
   end
   // ==========================================================================
   // Reset release
   logic [1:0] rst_pipe_q;
   logic       rst_n;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_q[1];
   // ==========================================================================
   // Line events
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end
   always_comb begin
      scl_rise   = scl_in && !scl_q;
      scl_fall   = !scl_in && scl_q;
      start_seen = scl_in && scl_q && sda_q && !sda_in;
      stop_seen  = scl_in && scl_q && !sda_q && sda_in;
   end
   // ==========================================================================
   // Register state
   logic [7:0] page_q, page_d;
   logic [7:0] err_q, err_d;
   logic [7:0] hp_q, hp_d;
   logic [7:0] spk_q, spk_d;
   logic       gain_rsv_q, gain_rsv_d;
   logic       hp_short_q;
   logic       spk_short_q;
   logic [6:0] gain_code;
   logic [6:0] ptr_q;
   logic [7:0] shift_q;
   logic       wr_en;
   logic       wr_ok;
   logic       hp_clear;
   logic       spk_clear;
   logic       hp_cut;
   logic       hp_limit;
   err_cfg_type cfg;
   assign cfg = '{spk_keep:  err_q[ERR_SPK_KEEP_BIT],
                  hp_keep:   err_q[ERR_HP_KEEP_BIT],
                  hp_action: hp_q[HP_ACTION_BIT]};
   gain_readout #(
      .GAIN_W     (7)
   ) u_gain (
      .clock      (clock),
      .rst_n      (rst_n),
      .code_in    (vol_code),
      .code_valid (vol_code_valid),
      .code_q     (gain_code),
      .half_db_q  (vol_gain_half_db)
   );
   short_guard u_guard (
      .hp_short   (hp_short_detect),
      .spk_short  (spk_short_detect),
      .cfg        (cfg),
      .hp_clear   (hp_clear),
      .spk_clear  (spk_clear),
      .hp_cut     (hp_cut),
      .hp_limit   (hp_limit)
   );
   // ==========================================================================
   // Register writes and hardware clears
   always_comb begin
      page_d     = page_q;
      err_d      = err_q;
      hp_d       = hp_q;
      spk_d      = spk_q;
      gain_rsv_d = gain_rsv_q;
      // Reserved ranges are not backed by storage, so writes there fall away.
      wr_ok = wr_en
              && !(page_q == PAGE_ZERO && ptr_q >= RSV0_LO_ADDR && ptr_q <= RSV0_HI_ADDR)
              && !(page_q == PAGE_ONE && ptr_q >= RSV1_LO_ADDR && ptr_q <= RSV1_HI_ADDR);
      if (wr_ok) begin
         if (ptr_q == PAGE_REG_ADDR) begin
            page_d = shift_q;
         end else if (page_q == PAGE_ZERO && ptr_q == GAIN_REG_ADDR) begin
            gain_rsv_d = shift_q[GAIN_RSV_BIT];
         end else if (page_q == PAGE_ONE && ptr_q == ERR_REG_ADDR) begin
            err_d = shift_q;
         end else if (page_q == PAGE_ONE && ptr_q == HP_REG_ADDR) begin
            hp_d = {shift_q[7:1], 1'b0};
         end else if (page_q == PAGE_ONE && ptr_q == SPK_REG_ADDR) begin
            spk_d = {shift_q[7:1], 1'b0};
         end
      end
      // Protection beats a software write that lands in the same cycle.
      if (hp_clear) begin
         hp_d[HP_LEFT_BIT]  = 1'b0;
         hp_d[HP_RIGHT_BIT] = 1'b0;
      end
      if (spk_clear) begin
         spk_d[SPK_LEFT_BIT]  = 1'b0;
         spk_d[SPK_RIGHT_BIT] = 1'b0;
      end
   end
   hp_drive_type  hp_drive_d;
   spk_drive_type spk_drive_d;
   always_comb begin
      hp_drive_d.left_up       = hp_d[HP_LEFT_BIT] && !hp_cut;
      hp_drive_d.right_up      = hp_d[HP_RIGHT_BIT] && !hp_cut;
      hp_drive_d.common_mode   = hp_d[HP_CM_LSB+1:HP_CM_LSB];
      hp_drive_d.current_limit = hp_limit;
      spk_drive_d.left_up      = spk_d[SPK_LEFT_BIT];
      spk_drive_d.right_up     = spk_d[SPK_RIGHT_BIT];
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         page_q      <= PAGE_RESET;
         err_q       <= ERR_RESET;
         hp_q        <= HP_RESET;
         spk_q       <= SPK_RESET;
         gain_rsv_q  <= GAIN_RSV_RESET;
         hp_short_q  <= 1'b0;
         spk_short_q <= 1'b0;
         hp_drive    <= '0;
         spk_drive   <= '0;
      end else begin
         page_q      <= page_d;
         err_q       <= err_d;
         hp_q        <= hp_d;
         spk_q       <= spk_d;
         gain_rsv_q  <= gain_rsv_d;
         hp_short_q  <= hp_short_detect;
         spk_short_q <= spk_short_detect;
         hp_drive    <= hp_drive_d;
         spk_drive   <= spk_drive_d;
      end
   end
   // ==========================================================================
   // Read data
   logic [7:0] rdata;
   always_comb begin
      rdata = 8'h00;
      if (ptr_q == PAGE_REG_ADDR) begin
         rdata = page_q;
      end else if (page_q == PAGE_ZERO && ptr_q == GAIN_REG_ADDR) begin
         rdata = {gain_rsv_q, gain_code};
      end else if (page_q == PAGE_ONE && ptr_q == ERR_REG_ADDR) begin
         rdata = err_q;
      end else if (page_q == PAGE_ONE && ptr_q == HP_REG_ADDR) begin
         rdata = {hp_q[7:1], hp_short_q};
      end else if (page_q == PAGE_ONE && ptr_q == SPK_REG_ADDR) begin
         rdata = {spk_q[7:1], spk_short_q};
      end
   end
   // ==========================================================================
   // Serial port sequencer
   port_state_type state_q, state_d;
   logic [3:0]     cnt_q, cnt_d;
   logic [7:0]     shift_d;
   logic [7:0]     tx_q, tx_d;
   logic [6:0]     ptr_d;
   logic           rd_q, rd_d;
   logic           oe_q, oe_d;
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      tx_d    = tx_q;
      ptr_d   = ptr_q;
      rd_d    = rd_q;
      oe_d    = oe_q;
      wr_en   = 1'b0;
      if (start_seen) begin
         state_d = ST_ADDR;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
      end else if (stop_seen) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (scl_rise) begin
         if (state_q == ST_RDATA_ACK && sda_in) begin
            state_d = ST_IDLE;
         end else if (state_q inside {ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA}) begin
            shift_d = {shift_q[6:0], sda_in};
            cnt_d   = cnt_q + 4'h1;
         end
      end else if (scl_fall) begin
         unique case (state_q)
            ST_IDLE: ;
            ST_ADDR: begin
               if (cnt_q == 4'h8) begin
                  cnt_d = 4'h0;
                  if (shift_q[7:1] == DEV_ADDR) begin
                     state_d = ST_ADDR_ACK;
                     rd_d    = shift_q[0];
                     oe_d    = 1'b1;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_PTR: begin
               if (cnt_q == 4'h8) begin
                  cnt_d   = 4'h0;
                  ptr_d   = shift_q[6:0];
                  oe_d    = 1'b1;
                  state_d = ST_PTR_ACK;
               end
            end
            ST_WDATA: begin
               if (cnt_q == 4'h8) begin
                  cnt_d   = 4'h0;
                  wr_en   = 1'b1;
                  ptr_d   = ptr_q + 7'h01;
                  oe_d    = 1'b1;
                  state_d = ST_WDATA_ACK;
               end
            end
            ST_ADDR_ACK: begin
               if (rd_q) begin
                  tx_d    = rdata;
                  oe_d    = !rdata[7];
                  state_d = ST_RDATA;
               end else begin
                  oe_d    = 1'b0;
                  state_d = ST_PTR;
               end
            end
            ST_PTR_ACK, ST_WDATA_ACK: begin
               oe_d    = 1'b0;
               state_d = ST_WDATA;
            end
            ST_RDATA: begin
               if (cnt_q == 4'h8) begin
                  cnt_d   = 4'h0;
                  oe_d    = 1'b0;
                  ptr_d   = ptr_q + 7'h01;
                  state_d = ST_RDATA_ACK;
               end else begin
                  tx_d = {tx_q[6:0], 1'b0};
                  oe_d = !tx_q[6];
               end
            end
            ST_RDATA_ACK: begin
               tx_d    = rdata;
               oe_d    = !rdata[7];
               state_d = ST_RDATA;
            end
            default: begin
               state_d = ST_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         tx_q    <= 8'h00;
         ptr_q   <= 7'h00;
         rd_q    <= 1'b0;
         oe_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         tx_q    <= tx_d;
         ptr_q   <= ptr_d;
         rd_q    <= rd_d;
         oe_q    <= oe_d;
      end
   end
   // Open drain: the line is only ever pulled low.
   assign sda_out = 1'b0;
   assign sda_oe  = oe_q;
endmodule
`default_nettype wire

// [output_driver_ctl_regs_chk.sv]
// Purpose: Port-level assertions for the output driver control registers.
// Assumes: One clock domain; arst_n is the only reset seen at the ports.
// Notes:   Gain checks allow one or two cycles of readout latency.
`timescale 1ns/1ns
`default_nettype none
module output_driver_ctl_regs_chk (
   // Clock and reset
   input wire logic                       clock,
   input wire logic                       arst_n,
   // Serial control port
   input wire logic                       scl_in,
   input wire logic                       sda_in,
   input wire logic                       sda_out,
   input wire logic                       sda_oe,
   // Driver status and converter
   input wire logic                       hp_short_detect,
   input wire logic                       spk_short_detect,
   input wire logic [6:0]                 vol_code,
   input wire logic                       vol_code_valid,
   input wire logic signed [7:0]          vol_gain_half_db,
   // Driver controls
   input wire drv_ctl_pkg::hp_drive_type  hp_drive,
   input wire drv_ctl_pkg::spk_drive_type spk_drive
);
   import drv_ctl_pkg::*;
   // ==========================================================================
   // Assertions
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   drop_code_a : assert property (vol_code_valid && vol_code == 7'h7F
      && !$past(vol_code_valid) |=> $stable(vol_gain_half_db) [*2])
      else $error("reserved gain code was taken");
   unity_gain_a : assert property (vol_code_valid && vol_code == 7'h24
      ##1 !vol_code_valid |=> vol_gain_half_db == 8'h00)
      else $error("unity code not reported as zero gain");
   upper_scale_a : assert property (vol_code_valid && vol_code <= 7'h5A
      ##1 !vol_code_valid |=> int'(vol_gain_half_db) == 36 - int'($past(vol_code, 2)))
      else $error("upper gain scale wrong");
   lower_scale_a : assert property (vol_code_valid && vol_code > 7'h5A
      && vol_code != 7'h7F ##1 !vol_code_valid
      |=> int'(vol_gain_half_db) == -54 - 2 * (int'($past(vol_code, 2)) - 90))
      else $error("lower gain scale wrong");
   // A limit without a short behind it would starve a healthy load.
   limit_cause_a : assert property (hp_drive.current_limit |-> $past(hp_short_detect))
      else $error("current limit without a short");
   short_cut_a : assert property ($past(hp_short_detect) && !hp_drive.current_limit
      |-> !hp_drive.left_up && !hp_drive.right_up) else $error("driver kept up during short");
   oe_steady_a : assert property (scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe))
      else $error("data line changed while serial clock high");
   open_drain_a : assert property (sda_out == 1'b0) else $error("data value not low");
endmodule
bind output_driver_ctl_regs output_driver_ctl_regs_chk chk_u (.clock(clock), .arst_n(arst_n),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .hp_short_detect(hp_short_detect), .spk_short_detect(spk_short_detect), .vol_code(vol_code),
   .vol_code_valid(vol_code_valid), .vol_gain_half_db(vol_gain_half_db), .hp_drive(hp_drive),
   .spk_drive(spk_drive));
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the output driver control registers.
// Assumes: The bench is the serial port master; the data line has a pull-up.
// Notes:   Register reads are queued and compared by a separate monitor.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import drv_ctl_pkg::*;
   // ==========================================================================
   // Signals
   localparam logic [6:0] DEV = 7'h2A;
   logic              clock;
   logic              arst_n;
   logic              scl_in;
   logic              sda_m;
   wire logic         sda_in;
   logic              sda_out;
   logic              sda_oe;
   logic              hp_short_detect;
   logic              spk_short_detect;
   logic [6:0]        vol_code;
   logic              vol_code_valid;
   logic signed [7:0] vol_gain_half_db;
   hp_drive_type      hp_drive;
   spk_drive_type     spk_drive;
   int                failures = 0;
   int                n_tests = 0;
   logic [7:0]        exp_q[$];
   logic [7:0]        rd_v;
   logic              ack_v;
   logic [6:0]        code;
   event              rd_ev;
   logic [6:0]        codes [11] = '{7'h00, 7'h01, 7'h02, 7'h23, 7'h24, 7'h25, 7'h59,
                                     7'h5A, 7'h5B, 7'h7D, 7'h7E};
   // Either party pulls the line low; nobody drives it high.
   assign sda_in = sda_m & ~sda_oe;
   output_driver_ctl_regs #(.DEV_ADDR(DEV)) dut_u (.clock(clock), .arst_n(arst_n),
      .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .hp_short_detect(hp_short_detect), .spk_short_detect(spk_short_detect),
      .vol_code(vol_code), .vol_code_valid(vol_code_valid),
      .vol_gain_half_db(vol_gain_half_db), .hp_drive(hp_drive), .spk_drive(spk_drive));
   // ==========================================================================
   // Tasks
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Each phase lasts at least four clocks so the sampler sees every level.
   task automatic bitx(input logic b, output logic r);
      sda_m = b;
      tk(4);
      scl_in = 1'b1;
      tk(2);
      r = sda_in;
      tk(2);
      scl_in = 1'b0;
      tk(1);
   endtask
   task automatic start();
      sda_m = 1'b1;
      tk(4);
      scl_in = 1'b1;
      tk(4);
      sda_m = 1'b0;
      tk(4);
      scl_in = 1'b0;
      tk(1);
   endtask
   task automatic stop();
      sda_m = 1'b0;
      tk(4);
      scl_in = 1'b1;
      tk(4);
      sda_m = 1'b1;
      tk(4);
   endtask
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
                       output logic a);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(m, a);
   endtask
   task automatic wb(input logic [7:0] d);
      logic [7:0] q;
      logic       a;
      xfer(d, 1'b1, q, a);
      chk({7'h00, a}, 8'h00);
   endtask
   task automatic wreg(input logic [6:0] ad, input logic [7:0] d);
      start();
      wb({DEV, 1'b0});
      wb({1'b0, ad});
      wb(d);
      stop();
   endtask
   task automatic rreg(input logic [6:0] ad, input logic [7:0] e);
      logic a;
      exp_q.push_back(e);
      start();
      wb({DEV, 1'b0});
      wb({1'b0, ad});
      start();
      wb({DEV, 1'b1});
      xfer(8'hFF, 1'b1, rd_v, a);
      stop();
      -> rd_ev;
   endtask
   task automatic vol(input logic [6:0] c);
      vol_code = c;
      vol_code_valid = 1'b1;
      tk(1);
      vol_code_valid = 1'b0;
      tk(3);
   endtask
   function automatic logic [7:0] hdb(input int c);
      return 8'(c <= 90 ? 36 - c : -54 - 2 * (c - 90));
   endfunction
   task automatic conclude();
      failures += exp_q.size();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================================================================
   // Clock, watchdog and read monitor
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (100000) @(posedge clock);
      failures++;
      conclude();
   end
   initial begin
      forever begin
         @(rd_ev);
         chk(rd_v, exp_q.pop_front());
      end
   end
   // ==========================================================================
   // Main sequence
   initial begin
      arst_n = 1'b0;
      scl_in = 1'b1;
      sda_m = 1'b1;
      hp_short_detect = 1'b0;
      spk_short_detect = 1'b0;
      vol_code = 7'h00;
      vol_code_valid = 1'b0;
      void'($urandom(32'hDF4C90D9));
      tk(4);
      arst_n = 1'b1;
      tk(6);
      chk({hp_drive, 3'h0}, 8'h00);
      rreg(PAGE_REG_ADDR, 8'h00);
      rreg(GAIN_REG_ADDR, 8'h24);
      start();
      xfer({DEV ^ 7'h01, 1'b0}, 1'b1, rd_v, ack_v);
      chk({7'h00, ack_v}, 8'h01);
      stop();
      wreg(PAGE_REG_ADDR, 8'hFF);
      rreg(PAGE_REG_ADDR, 8'hFF);
      wreg(PAGE_REG_ADDR, 8'h01);
      rreg(ERR_REG_ADDR, 8'h00);
      rreg(HP_REG_ADDR, 8'h04);
      rreg(SPK_REG_ADDR, 8'h06);
      wreg(SPK_REG_ADDR + 7'h01, 8'h55);
      rreg(SPK_REG_ADDR + 7'h01, 8'h00);
      rreg(RSV1_LO_ADDR + 7'h04, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wreg(HP_REG_ADDR, {2'b11, 1'b0, 2'(c), 3'b100});
         chk({6'h00, hp_drive.common_mode}, 8'(c));
         chk({6'h00, hp_drive.left_up, hp_drive.right_up}, 8'h03);
      end
      wreg(HP_REG_ADDR, 8'hC6);
      hp_short_detect = 1'b1;
      tk(2);
      chk({6'h00, hp_drive.left_up, hp_drive.right_up}, 8'h00);
      rreg(HP_REG_ADDR, 8'h07);
      hp_short_detect = 1'b0;
      tk(2);
      chk({6'h00, hp_drive.left_up, hp_drive.right_up}, 8'h00);
      wreg(HP_REG_ADDR, 8'hC5);
      hp_short_detect = 1'b1;
      tk(2);
      chk({6'h00, hp_drive.current_limit, hp_drive.left_up}, 8'h03);
      hp_short_detect = 1'b0;
      tk(2);
      rreg(HP_REG_ADDR, 8'hC4);
      wreg(ERR_REG_ADDR, 8'h01);
      wreg(HP_REG_ADDR, 8'hC6);
      hp_short_detect = 1'b1;
      tk(2);
      rreg(HP_REG_ADDR, 8'hC7);
      hp_short_detect = 1'b0;
      tk(2);
      chk({6'h00, hp_drive.left_up, hp_drive.right_up}, 8'h03);
      for (int k = 0; k < 2; k++) begin
         wreg(ERR_REG_ADDR, {6'h00, 1'(k), 1'b0});
         wreg(SPK_REG_ADDR, 8'hC6);
         chk({6'h00, spk_drive}, 8'h03);
         spk_short_detect = 1'b1;
         tk(2);
         chk({6'h00, spk_drive}, (k == 1) ? 8'h03 : 8'h00);
         rreg(SPK_REG_ADDR, (k == 1) ? 8'hC7 : 8'h07);
         spk_short_detect = 1'b0;
         tk(2);
      end
      wreg(PAGE_REG_ADDR, 8'h00);
      foreach (codes[i]) begin
         vol(codes[i]);
         chk(vol_gain_half_db, hdb(codes[i]));
      end
      vol(7'h7F);
      chk(vol_gain_half_db, hdb(126));
      repeat (4) begin
         code = 7'($urandom % 127);
         vol(code);
         chk(vol_gain_half_db, hdb(code));
         wreg(GAIN_REG_ADDR, 8'h00);
         rreg(GAIN_REG_ADDR, {1'b0, code});
      end
      tk(2);
      conclude();
   end
endmodule
`default_nettype wire
